// ==== ubcf_framer.sv ====
// upstream burst codeword framer: splits a burst into info blocks and zero-fills the grant
`timescale 1ns/100ps

// Summary of operation
// R1 - With the coder on, each burst is framed either as fixed-length codewords only or as full codewords plus one shortened final codeword.
// R2 - No coded codeword carries fewer than sixteen information bytes, so a coded burst with k below sixteen is refused.
// R3 - Framing is the same whether the grant lies in a contention or a non-contention region, so no region input exists.
// R4 - In fixed mode the last data codeword is zero-padded to k and zero codewords follow while a whole codeword with parity fits.
// R5 - In shortened mode burst bytes are packed k to a codeword until the data ends or less than k is left.
// R6 - A shortened final codeword holds at least sixteen information bytes, which the requester must allow for.
// R7 - In shortened mode the final codeword is sized to use up the grant after parity and guard, padded with zeros.
// R8 - Zero-filled full codewords come first while they fit, then one shortened codeword where room remains.
// R9 - If under sixteen information bytes of room remain after the full codewords, no shortened codeword is made.
// R10 - Output leaves as information blocks with codeword marks, ready for coding, scrambling, preamble, mapping and modulation.
// R11 - With the coder off, blocks are marked to pass without parity and no parity room is reserved.
// R12 - Grant capacity, k, parity length and guard overhead are taken per burst and codeword counts are planned before output.
module ubcf_framer (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic burst_start,
    input wire logic cfg_fec_en,
    input wire logic cfg_short_mode,
    input wire logic [ubcf_pkg::K_W-1:0] cfg_info_len,
    input wire logic [ubcf_pkg::K_W-1:0] cfg_parity_len,
    input wire logic [ubcf_pkg::LEN_W-1:0] cfg_guard_len,
    input wire logic [ubcf_pkg::LEN_W-1:0] cfg_grant_len,
    input wire logic [ubcf_pkg::LEN_W-1:0] cfg_pkt_len,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [7:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [7:0] out_data,
    output logic out_cw_first,
    output logic out_cw_last,
    output logic out_burst_last,
    output logic out_parity_en,
    output logic busy,
    output logic burst_done,
    output logic cfg_error,
    output logic data_overflow,
    output logic [ubcf_pkg::LEN_W-1:0] plan_full_cw,
    output logic [ubcf_pkg::K_W-1:0] plan_short_len
);
    import ubcf_pkg::*;

    // bytes one codeword takes from the grant
    function automatic logic [LEN_W-1:0] cw_cost(input logic [K_W-1:0] info, input logic [K_W-1:0] par);
        cw_cost = {8'h00, info} + {8'h00, par};
    endfunction

    ubcf_state_t st_r, st_nxt;
    logic fec_r;
    logic short_r;
    logic [K_W-1:0] k_r;
    logic [K_W-1:0] par_r;
    logic [LEN_W-1:0] cap_r, cap_nxt;
    logic [LEN_W-1:0] nfull_r, nfull_nxt;
    logic [K_W-1:0] slen_r, slen_nxt;
    logic [LEN_W-1:0] data_left_r, data_left_nxt;
    logic [LEN_W-1:0] cw_idx_r, cw_idx_nxt;
    logic [K_W-1:0] byte_idx_r, byte_idx_nxt;
    logic out_valid_r;
    logic out_cw_first_r;
    logic out_cw_last_r;
    logic out_burst_last_r;
    logic out_parity_en_r;
    logic [7:0] out_data_r;
    logic done_r;
    logic err_r;
    logic ovf_r;

    wire logic bad_cfg;
    wire logic [K_W-1:0] eff_par;
    wire logic [LEN_W-1:0] start_cap;
    wire logic [LEN_W-1:0] full_cost;
    wire logic full_fits;
    wire logic short_fits;
    wire logic [LEN_W-1:0] short_room;
    wire logic [LEN_W-1:0] total_cw;
    wire logic [K_W-1:0] cur_len;
    wire logic need_data;
    wire logic out_free;
    wire logic adv;
    wire logic at_cw_last;
    wire logic at_burst_last;
    wire logic [7:0] next_byte;

    // a coded burst with k under the minimum is refused; k of zero never frames
    assign bad_cfg = (cfg_info_len == K_ZERO) || (cfg_fec_en && (cfg_info_len < MIN_INFO_BYTES)); // see R2
    // no parity room is held back when the coder is off
    assign eff_par = cfg_fec_en ? cfg_parity_len : K_ZERO; // see R11
    // region of the grant plays no part in the plan
    assign start_cap = (cfg_grant_len > cfg_guard_len) ? cfg_grant_len - cfg_guard_len : LEN_ZERO; // see R3
    assign full_cost = cw_cost(k_r, par_r);
    assign full_fits = cap_r >= full_cost; // see R4
    assign short_room = cap_r - {8'h00, par_r};
    // shortened tail only when coding, in shortened mode, and at least the minimum fits
    assign short_fits = fec_r && short_r && (cap_r >= cw_cost(MIN_INFO_BYTES, par_r)); // see R9
    assign total_cw = nfull_r + ((slen_r != K_ZERO) ? LEN_ONE : LEN_ZERO);
    assign cur_len = (cw_idx_r < nfull_r) ? k_r : slen_r; // see R1
    assign need_data = data_left_r != LEN_ZERO;
    assign out_free = !out_valid_r || out_ready;
    assign adv = (st_r == UBCF_EMIT) && out_free && (!need_data || in_valid);
    assign at_cw_last = byte_idx_r == (cur_len - K_ONE);
    assign at_burst_last = at_cw_last && (cw_idx_r == (total_cw - LEN_ONE));
    // burst bytes first, then zero fill to the end of the allocation
    assign next_byte = need_data ? in_data : ZERO_FILL_BYTE; // see R5
    assign in_ready = (st_r == UBCF_EMIT) && need_data && out_free;

    always_comb begin
        st_nxt = st_r;
        cap_nxt = cap_r;
        nfull_nxt = nfull_r;
        slen_nxt = slen_r;
        data_left_nxt = data_left_r;
        cw_idx_nxt = cw_idx_r;
        byte_idx_nxt = byte_idx_r;
        unique case (st_r)
            UBCF_IDLE: begin
                if (burst_start && !bad_cfg) begin
                    cap_nxt = start_cap; // see R12
                    nfull_nxt = LEN_ZERO;
                    slen_nxt = K_ZERO;
                    data_left_nxt = cfg_pkt_len;
                    cw_idx_nxt = LEN_ZERO;
                    byte_idx_nxt = K_ZERO;
                    st_nxt = UBCF_PLAN;
                end
            end
            UBCF_PLAN: begin
                // one codeword is planned per cycle; long grants take longer to plan
                if (full_fits) begin
                    cap_nxt = cap_r - full_cost; // see R8
                    nfull_nxt = nfull_r + LEN_ONE;
                end else begin
                    // tail uses all room left after parity, always below k here
                    if (short_fits) begin
                        slen_nxt = short_room[K_W-1:0]; // see R7
                    end
                    st_nxt = (nfull_r == LEN_ZERO && !short_fits) ? UBCF_DONE : UBCF_EMIT;
                end
            end
            UBCF_EMIT: begin
                if (adv) begin
                    if (need_data) begin
                        data_left_nxt = data_left_r - LEN_ONE;
                    end
                    if (at_cw_last) begin
                        byte_idx_nxt = K_ZERO;
                        cw_idx_nxt = cw_idx_r + LEN_ONE;
                    end else begin
                        byte_idx_nxt = byte_idx_r + K_ONE;
                    end
                    if (at_burst_last) begin
                        st_nxt = UBCF_DONE;
                    end
                end
            end
            UBCF_DONE: begin
                st_nxt = UBCF_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_r <= UBCF_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cap_r <= LEN_ZERO;
        end else begin
            cap_r <= cap_nxt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            nfull_r <= LEN_ZERO;
        end else begin
            nfull_r <= nfull_nxt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            slen_r <= K_ZERO;
        end else begin
            slen_r <= slen_nxt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            data_left_r <= LEN_ZERO;
        end else begin
            data_left_r <= data_left_nxt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cw_idx_r <= LEN_ZERO;
        end else begin
            cw_idx_r <= cw_idx_nxt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            byte_idx_r <= K_ZERO;
        end else begin
            byte_idx_r <= byte_idx_nxt;
        end
    end

    // burst settings are frozen at the start so mid-burst changes cannot skew the plan
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            fec_r <= 1'b0;
        end else if (st_r == UBCF_IDLE && burst_start) begin
            fec_r <= cfg_fec_en;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            short_r <= 1'b0;
        end else if (st_r == UBCF_IDLE && burst_start) begin
            short_r <= cfg_short_mode;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            k_r <= K_ZERO;
        end else if (st_r == UBCF_IDLE && burst_start) begin
            k_r <= cfg_info_len;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            par_r <= K_ZERO;
        end else if (st_r == UBCF_IDLE && burst_start) begin
            par_r <= eff_par;
        end
    end

    // registered output stage; marks tell the coder where each block starts and ends
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            out_valid_r <= 1'b0;
            out_data_r <= ZERO_FILL_BYTE;
            out_cw_first_r <= 1'b0;
            out_cw_last_r <= 1'b0;
            out_burst_last_r <= 1'b0;
            out_parity_en_r <= 1'b0;
        end else if (adv) begin
            out_valid_r <= 1'b1;
            out_data_r <= next_byte;
            out_cw_first_r <= byte_idx_r == K_ZERO; // see R10
            out_cw_last_r <= at_cw_last;
            out_burst_last_r <= at_burst_last;
            out_parity_en_r <= fec_r; // see R11
        end else if (out_ready) begin
            out_valid_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            done_r <= 1'b0;
            err_r <= 1'b0;
            ovf_r <= 1'b0;
        end else begin
            done_r <= (st_r == UBCF_DONE);
            if (st_r == UBCF_IDLE && burst_start) begin
                // requester gave k of zero, or k under the minimum block with the coder on
                err_r <= bad_cfg; // see R2
                ovf_r <= 1'b0;
            end else if (st_r != UBCF_IDLE && st_nxt == UBCF_DONE) begin
                // bytes left over are not taken; the source must drop them itself
                ovf_r <= data_left_nxt != LEN_ZERO;
            end
        end
    end

    assign out_valid = out_valid_r;
    assign out_data = out_data_r;
    assign out_cw_first = out_cw_first_r;
    assign out_cw_last = out_cw_last_r;
    assign out_burst_last = out_burst_last_r;
    assign out_parity_en = out_parity_en_r;
    assign busy = st_r != UBCF_IDLE;
    assign burst_done = done_r;
    assign cfg_error = err_r;
    assign data_overflow = ovf_r;
    assign plan_full_cw = nfull_r;
    assign plan_short_len = slen_r;
endmodule

// ==== ubcf_framer_tb.sv ====
// self-checking testbench for the upstream burst codeword framer
`timescale 1ns/100ps
module ubcf_framer_tb;
    import ubcf_pkg::*;
    logic ref_clk = 0, sys_rst = 1, burst_start = 0, cfg_fec_en = 0, cfg_short_mode = 0, in_valid = 0, slow = 0;
    logic [K_W-1:0] cfg_info_len = K_ONE, cfg_parity_len = K_ZERO, plan_short_len;
    logic [LEN_W-1:0] cfg_guard_len = LEN_ZERO, cfg_grant_len = LEN_ZERO, cfg_pkt_len = LEN_ZERO, plan_full_cw;
    logic [7:0] in_data = 8'h00, out_data;
    logic in_ready, out_valid, out_ready, out_cw_first, out_cw_last, out_burst_last, out_parity_en;
    logic busy, burst_done, cfg_error, data_overflow;
    int errors = 0, compares = 0, idx = 0;
    ubcf_framer DUT (.*);
    ubcf_sink P (.*);
    initial forever #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (in_valid && in_ready) idx <= idx + 1;
    always @(negedge ref_clk) begin
        in_valid <= idx < int'(cfg_pkt_len);
        in_data <= 8'(idx + 8'h11);
    end
    task automatic tally_and_finish;
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic run(input logic fe, sm, input logic [7:0] k, p, input logic [15:0] g, gr, pk);
        int n;
        @(negedge ref_clk);
        {cfg_fec_en, cfg_short_mode, cfg_info_len, cfg_parity_len} = {fe, sm, k, p};
        {cfg_guard_len, cfg_grant_len, cfg_pkt_len} = {g, gr, pk};
        idx = 0;
        P.got.delete();
        P.cw_n = 0;
        P.first_n = 0;
        P.end_n = 0;
        P.par_n = 0;
        burst_start = 1;
        @(negedge ref_clk);
        burst_start = 0;
        for (n = 0; n < 3000 && burst_done !== 1'b1 && cfg_error !== 1'b1; n++) @(negedge ref_clk);
        if (n == 3000) begin
            errors++;
            tally_and_finish();
        end
        // a stalling sink may still hold the last byte after done
        for (n = 0; n < 16 && out_valid !== 1'b0; n++) @(negedge ref_clk);
        if (n == 16) begin
            errors++;
            tally_and_finish();
        end
    endtask
    // byte i is data while i < pk, then zero fill
    task automatic check_out(input int nf, tl, k, pk);
        chk(16'(P.got.size()), 16'(nf * k + tl));
        chk(plan_full_cw, 16'(nf));
        chk(16'(plan_short_len), 16'(tl));
        chk(16'(P.cw_n), 16'(nf + int'(tl > 0)));
        chk(16'(P.first_n), 16'(nf + int'(tl > 0)));
        chk(16'(P.end_n), 16'h0001);
        chk(16'(P.par_n), cfg_fec_en ? 16'(nf * k + tl) : 16'h0000);
        foreach (P.got[i]) chk(16'(P.got[i]), 16'(i < pk ? 8'(i + 8'h11) : 8'h00));
    endtask
    task automatic t_badk;
        run(1, 0, 8'h0F, 8'h04, 16'h0000, 16'h0040, 16'h0004);
        chk(16'({cfg_error, busy}), 16'h0002);
        run(0, 0, 8'h00, 8'h00, 16'h0000, 16'h0040, 16'h0004);
        chk(16'({cfg_error, busy}), 16'h0002);
    endtask
    task automatic t_fixed;
        run(1, 0, 8'h14, 8'h04, 16'h0006, 16'h003C, 16'h0019);
        chk(16'(cfg_error), 16'h0000);
        check_out(2, 0, 20, 25);
    endtask
    // 68 usable: two 24-byte codewords, 20 left gives a 16-byte tail
    task automatic t_short;
        slow = 1;
        run(1, 1, 8'h14, 8'h04, 16'h0004, 16'h0048, 16'h001E);
        check_out(2, 16, 20, 30);
        slow = 0;
    endtask
    task automatic t_notail;
        run(1, 1, 8'h14, 8'h04, 16'h0004, 16'h0047, 16'h001E);
        check_out(2, 0, 20, 30);
    endtask
    // coder off: no parity room, so two 8-byte blocks fit in 20; 2 of the 18 bytes overflow
    task automatic t_off;
        run(0, 1, 8'h08, 8'h04, 16'h0000, 16'h0014, 16'h0012);
        check_out(2, 0, 8, 18);
        chk(16'(data_overflow), 16'h0001);
    endtask
    initial begin
        repeat (5) @(negedge ref_clk);
        sys_rst = 0;
        t_badk();
        t_fixed();
        t_short();
        t_notail();
        t_off();
        tally_and_finish();
    end
endmodule

// ==== ubcf_pkg.sv ====
// constants and types for the upstream burst codeword framer
package ubcf_pkg;
    localparam int LEN_W = 16;
    localparam int K_W = 8;
    localparam logic [K_W-1:0] MIN_INFO_BYTES = 8'h10;
    localparam logic [7:0] ZERO_FILL_BYTE = 8'h00;
    localparam logic [LEN_W-1:0] LEN_ZERO = 16'h0000;
    localparam logic [LEN_W-1:0] LEN_ONE = 16'h0001;
    localparam logic [K_W-1:0] K_ZERO = 8'h00;
    localparam logic [K_W-1:0] K_ONE = 8'h01;
    typedef enum logic [1:0] {
        UBCF_IDLE,
        UBCF_PLAN,
        UBCF_EMIT,
        UBCF_DONE
    } ubcf_state_t;
endpackage

// ==== ubcf_sink.sv ====
// headend receiver model: collects framed bytes, can stall
`timescale 1ns/100ps
module ubcf_sink (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic slow,
    input wire logic out_valid,
    input wire logic [7:0] out_data,
    input wire logic out_cw_last,
    input wire logic out_cw_first,
    input wire logic out_burst_last,
    input wire logic out_parity_en,
    output logic out_ready
);
    logic [7:0] got[$];
    int cw_n = 0;
    int first_n = 0;
    int end_n = 0;
    int par_n = 0;
    logic [1:0] ph_r;
    // same framing expected in any region; slow takes one byte in three
    assign out_ready = !slow || ph_r == 2'h0;
    always @(posedge ref_clk) begin
        ph_r <= (sys_rst || ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
        if (!sys_rst && out_valid && out_ready) begin
            got.push_back(out_data);
            cw_n += int'(out_cw_last);
            first_n += int'(out_cw_first);
            end_n += int'(out_burst_last);
            par_n += int'(out_parity_en);
        end
    end
endmodule

// ==== ubcf_sva.sv ====
// port assertions for the upstream burst codeword framer
`timescale 1ns/100ps
module ubcf_chk import ubcf_pkg::*; (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic burst_start,
    input wire logic cfg_fec_en,
    input wire logic [K_W-1:0] cfg_info_len,
    input wire logic in_ready,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic [7:0] out_data,
    input wire logic out_cw_first,
    input wire logic out_cw_last,
    input wire logic out_burst_last,
    input wire logic out_parity_en,
    input wire logic busy,
    input wire logic burst_done,
    input wire logic cfg_error,
    input wire logic [K_W-1:0] plan_short_len
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    sequence s_take;
        burst_start && !busy;
    endsequence
    sequence s_cw_end;
        out_valid && out_ready && out_cw_last && !out_burst_last;
    endsequence
    a_start_busy: assert property (s_take ##0 cfg_info_len >= MIN_INFO_BYTES |=> busy && !cfg_error)
        else $error("start not taken");
    a_bad_k: assert property (s_take ##0 (cfg_fec_en && cfg_info_len < MIN_INFO_BYTES) |=> cfg_error && !busy)
        else $error("short k not refused");
    a_valid_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("output dropped while stalled");
    a_tail_min: assert property (plan_short_len != K_ZERO |-> plan_short_len >= MIN_INFO_BYTES)
        else $error("tail below minimum");
    a_parity_sel: assert property (out_valid |-> out_parity_en == cfg_fec_en)
        else $error("parity mark wrong");
    a_cw_order: assert property (s_cw_end |=> ##[0:8] (out_valid && out_cw_first))
        else $error("no codeword start after end");
    a_burst_end: assert property (out_valid && out_burst_last |-> out_cw_last)
        else $error("burst ends inside codeword");
    a_done_pulse: assert property (burst_done |-> !busy ##1 !burst_done)
        else $error("done not a pulse");
    a_in_gate: assert property (in_ready |-> busy && (!out_valid || out_ready))
        else $error("input taken out of turn");
endmodule
bind ubcf_framer ubcf_chk u_chk (.*);
